/* rtl/ebp_defs.vh */
// Register map, field positions, reset values and timing counts
`ifndef EBP_DEFS_VH
`define EBP_DEFS_VH

// Printed register indexes; byte address is four times the index
`define EBP_IDX_DUTY_HIGH    8'h13
`define EBP_IDX_DUTY_LATCH   8'h14
`define EBP_IDX_MODULE_CTRL  8'h15
`define EBP_IDX_DEADBAND     8'h16
`define EBP_IDX_PERIOD_LIMIT 8'h20
`define EBP_IDX_TIMER_CTRL   8'h21
`define EBP_IDX_STATUS       8'h22

// Module control fields
`define EBP_CFG_HI      7
`define EBP_CFG_LO      6
`define EBP_DUTYLO_HI   5
`define EBP_DUTYLO_LO   4
`define EBP_MODE_HI     3
`define EBP_MODE_LO     0
`define EBP_PWM_MODE_HI 2'b11

// Output configurations
`define EBP_CFG_SINGLE  2'b00
`define EBP_CFG_FULLFWD 2'b01
`define EBP_CFG_HALF    2'b10
`define EBP_CFG_FULLREV 2'b11

// Timer control fields
`define EBP_TON_BIT     2
`define EBP_PS_1        2'b00
`define EBP_PS_4        2'b01

// Reset values
`define EBP_RST_BYTE    8'h00
`define EBP_RST_DUTY    10'h000
`define EBP_RST_PERIOD  8'hff

// Oscillator clocks per instruction cycle; prescale spans in oscillator clocks, minus one
`define EBP_TOSC_PER_TCY 4
`define EBP_SUB_LAST_1   6'h03
`define EBP_SUB_LAST_4   6'h0f
`define EBP_SUB_LAST_16  6'h3f

// Bus responses
`define EBP_RESP_OKAY   2'b00
`define EBP_RESP_SLVERR 2'b10

`endif

/* rtl/ebp_timebase.v */
// Period timer with prescaler, quarter-cycle phase and period events
`timescale 1ns/10ps
`include "ebp_defs.vh"
module ebp_timebase (
	input  wire       clk,          // Oscillator clock
	input  wire       rst,          // Async reset, active high
	input  wire       timer_on,     // Timer run enable
	input  wire [1:0] prescale_sel, // Prescale select
	input  wire [7:0] period_limit, // Period limit value
	output reg  [7:0] period_timer, // Timer count
	output reg  [1:0] fine_bits,    // Two low compare bits
	output wire       tcy,          // Last clock of each instruction cycle
	output reg        period_start, // First clock of a new period
	output wire       last_count    // Timer sits at the period limit
);
	reg  [5:0] sub_reg;
	reg  [5:0] sub_last;

	// Span of one timer increment
	always @* begin
		case (prescale_sel)
			`EBP_PS_1: sub_last = `EBP_SUB_LAST_1;
			`EBP_PS_4: sub_last = `EBP_SUB_LAST_4;
			default:   sub_last = `EBP_SUB_LAST_16;
		endcase
	end

	// Low compare bits: quarter phase or prescaler bits
	always @* begin
		case (prescale_sel)
			`EBP_PS_1: fine_bits = sub_reg[1:0];
			`EBP_PS_4: fine_bits = sub_reg[3:2];
			default:   fine_bits = sub_reg[5:4];
		endcase
	end

	assign tcy        = timer_on & (sub_reg[1:0] == 2'b11);
	assign last_count = timer_on & (period_timer == period_limit);

	// Counter chain; clears on the increment after the limit match
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			sub_reg      <= 6'h00;
			period_timer <= 8'h00;
			period_start <= 1'b0;
		end else if (!timer_on) begin
			sub_reg      <= 6'h00;
			period_timer <= 8'h00;
			period_start <= 1'b0;
		end else if (sub_reg >= sub_last) begin
			sub_reg <= 6'h00;
			if (period_timer == period_limit) begin
				period_timer <= 8'h00;
				period_start <= 1'b1;
			end else begin
				period_timer <= period_timer + 8'h01;
				period_start <= 1'b0;
			end
		end else begin
			sub_reg      <= sub_reg + 6'h01;
			period_start <= 1'b0;
		end
	end
endmodule // ebp_timebase

/* rtl/ebp_deadband.v */
// Rising-edge delay in instruction cycles for one bridge output
`timescale 1ns/10ps
module ebp_deadband (
	input  wire       clk,      // Oscillator clock
	input  wire       rst,      // Async reset, active high
	input  wire       load,     // Delay load strobe
	input  wire [6:0] count_in, // Programmed delay count
	input  wire       raw,      // Undelayed level
	output reg        out       // Delayed level
);
	reg [6:0] delay_reg;
	reg [6:0] cnt_reg;
	reg [1:0] phase_reg;

	// Delay value taken at duty or period boundary
	always @(posedge clk or posedge rst) begin
		if (rst)
			delay_reg <= 7'h00;
		else if (load)
			delay_reg <= count_in;
	end

	// Only inactive-to-active edges are delayed; own phase from the edge
	// keeps the wait a whole number of instruction cycles
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			out       <= 1'b0;
			cnt_reg   <= 7'h00;
			phase_reg <= 2'b00;
		end else if (!raw) begin
			out       <= 1'b0;
			cnt_reg   <= 7'h00;
			phase_reg <= 2'b00;
		end else if (!out) begin
			if (cnt_reg >= delay_reg) begin
				out <= 1'b1;
			end else begin
				phase_reg <= phase_reg + 2'b01;
				if (phase_reg == 2'b11)
					cnt_reg <= cnt_reg + 7'h01;
			end
		end
	end
endmodule // ebp_deadband

/* rtl/ebp_bridge_pwm.v */
// Enhanced bridge PWM generator with AXI4-Lite register slave
// Functional notes
// - Two-bit field selects one of four configurations
// - Control byte pattern assigns one, two, four pins
// - Cleared control register forces outputs inactive
// - Period is (limit+1) times four times prescale
// - Period end: clear timer, set output, latch duty
// - Ten-bit duty: buffer byte plus two control bits
// - Duty latch read-only while PWM mode selected
// - Active phase ends on ten-bit duty match
// - Half-bridge turn-on edges wait for dead band expiry
// - Polarity and mode from config and mode fields
// - Controls double-buffered, loaded at period boundary
// - Dead band loads at duty or period boundary
// - Buffered waveforms lag one oscillator clock
// - Duty beyond period leaves outputs unchanged
// - Half-bridge: PWM on A, complement on B
// - Half-bridge waits delay count before going active
// - Delay above duty keeps output inactive all cycle
// - Forward: A on, D modulated; reverse: C, B
// - Direction change applies from next period
// - Last timer count: B, D off, A and C swap
// - Full-bridge uses no dead band delay
// - Mode bit 1 inverts A/C, bit 0 B/D
// - Delay only on inactive-to-active, instruction cycles
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "ebp_defs.vh"
module ebp_bridge_pwm (
	input  wire        clk,           // Oscillator clock, 250 MHz
	input  wire        rst,           // Async reset, active high
	input  wire [31:0] s_axi_awaddr,  // Write address
	input  wire        s_axi_awvalid, // Write address valid
	output reg         s_axi_awready, // Write address ready
	input  wire [31:0] s_axi_wdata,   // Write data
	input  wire [3:0]  s_axi_wstrb,   // Write byte strobes
	input  wire        s_axi_wvalid,  // Write data valid
	output reg         s_axi_wready,  // Write data ready
	output reg  [1:0]  s_axi_bresp,   // Write response
	output reg         s_axi_bvalid,  // Write response valid
	input  wire        s_axi_bready,  // Write response ready
	input  wire [31:0] s_axi_araddr,  // Read address
	input  wire        s_axi_arvalid, // Read address valid
	output reg         s_axi_arready, // Read address ready
	output reg  [31:0] s_axi_rdata,   // Read data
	output reg  [1:0]  s_axi_rresp,   // Read response
	output reg         s_axi_rvalid,  // Read data valid
	input  wire        s_axi_rready,  // Read data ready
	output reg         pwm_out_a,     // Bridge output A
	output reg         pwm_out_b,     // Bridge output B
	output reg         pwm_out_c,     // Bridge output C
	output reg         pwm_out_d,     // Bridge output D
	output reg  [3:0]  pwm_pin_own    // Pins owned by PWM, D..A
);
	// Software-visible registers
	reg  [7:0]  module_control_reg;
	reg  [7:0]  duty_high_buffer;
	reg  [7:0]  duty_compare_latch;
	reg  [7:0]  period_limit_reg;
	reg  [7:0]  period_timer_control;
	reg  [7:0]  deadband_config_reg;

	// Period-boundary shadows
	reg  [1:0]  cfg_sh_reg;
	reg  [3:0]  mode_sh_reg;
	reg  [1:0]  duty_lo_sh_reg;
	reg         pwm_raw_reg;

	// Bus holding registers
	reg  [31:0] awaddr_reg;
	reg  [7:0]  wbyte_reg;
	reg         wlane_reg;

	// Next values
	reg         a_next;
	reg         b_next;
	reg         c_next;
	reg         d_next;
	reg  [3:0]  own_next;
	reg  [31:0] rd_next;
	reg         rd_hit;

	wire [7:0]  period_timer;
	wire [1:0]  fine_bits;
	wire        period_start;
	wire        last_count;
	wire        db_a;
	wire        db_b;
	wire        duty_match;
	wire        pwm_sel_live;
	wire        pwm_sel_sh;
	wire [9:0]  duty_latched;
	wire        dir_live;
	wire        full_sh;
	wire        wr_go;

	// Register index from a word-aligned byte address
	function [7:0] reg_index;
		input [31:0] addr;
		begin
			reg_index = addr[9:2];
		end
	endfunction

	// Address is one of the mapped words
	function mapped;
		input [31:0] addr;
		reg [7:0] idx;
		begin
			idx    = reg_index(addr);
			mapped = (addr[31:10] == 22'h000000) && (addr[1:0] == 2'b00)
				&& ((idx == `EBP_IDX_DUTY_HIGH)
				|| (idx == `EBP_IDX_DUTY_LATCH)
				|| (idx == `EBP_IDX_MODULE_CTRL)
				|| (idx == `EBP_IDX_DEADBAND)
				|| (idx == `EBP_IDX_PERIOD_LIMIT)
				|| (idx == `EBP_IDX_TIMER_CTRL)
				|| (idx == `EBP_IDX_STATUS));
		end
	endfunction

	assign pwm_sel_live = module_control_reg[`EBP_MODE_HI:`EBP_MODE_HI-1]
		== `EBP_PWM_MODE_HI;
	assign pwm_sel_sh   = mode_sh_reg[3:2] == `EBP_PWM_MODE_HI;
	assign duty_latched = {duty_compare_latch, duty_lo_sh_reg};
	assign dir_live     = module_control_reg[`EBP_CFG_HI];
	assign full_sh      = cfg_sh_reg[0];
	assign duty_match   = pwm_sel_sh
		& (duty_latched == {period_timer, fine_bits});
	assign wr_go        = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

	// Period timer and prescaler
	ebp_timebase u_timebase (
		.clk          (clk),
		.rst          (rst),
		.timer_on     (period_timer_control[`EBP_TON_BIT]),
		.prescale_sel (period_timer_control[1:0]),
		.period_limit (period_limit_reg),
		.period_timer (period_timer),
		.fine_bits    (fine_bits),
		.tcy          (),
		.period_start (period_start),
		.last_count   (last_count)
	);

	// Dead band on the true and complement half-bridge legs
	ebp_deadband u_db_a (
		.clk      (clk),
		.rst      (rst),
		.load     (period_start | duty_match),
		.count_in (deadband_config_reg[6:0]),
		.raw      (pwm_raw_reg),
		.out      (db_a)
	);

	ebp_deadband u_db_b (
		.clk      (clk),
		.rst      (rst),
		.load     (period_start | duty_match),
		.count_in (deadband_config_reg[6:0]),
		.raw      (~pwm_raw_reg & pwm_sel_sh),
		.out      (db_b)
	);

	// Write channel: address and data taken in either order
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `EBP_RESP_OKAY;
			awaddr_reg    <= 32'h00000000;
			wbyte_reg     <= `EBP_RST_BYTE;
			wlane_reg     <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				awaddr_reg    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wbyte_reg    <= s_axi_wdata[7:0];
				wlane_reg    <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(awaddr_reg) ? `EBP_RESP_OKAY
					: `EBP_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Register writes; byte lane 0 carries every field
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			module_control_reg   <= `EBP_RST_BYTE;
			duty_high_buffer     <= `EBP_RST_BYTE;
			duty_compare_latch   <= `EBP_RST_BYTE;
			period_limit_reg     <= `EBP_RST_PERIOD;
			period_timer_control <= `EBP_RST_BYTE;
			deadband_config_reg  <= `EBP_RST_BYTE;
		end else begin
			if (wr_go && wlane_reg && mapped(awaddr_reg)) begin
				case (reg_index(awaddr_reg))
				`EBP_IDX_MODULE_CTRL:  module_control_reg <= wbyte_reg;
				`EBP_IDX_DUTY_HIGH:    duty_high_buffer <= wbyte_reg;
				`EBP_IDX_PERIOD_LIMIT: period_limit_reg <= wbyte_reg;
				`EBP_IDX_TIMER_CTRL:   period_timer_control <= wbyte_reg;
				`EBP_IDX_DEADBAND:
					deadband_config_reg <= {1'b0, wbyte_reg[6:0]};
				`EBP_IDX_DUTY_LATCH: begin
					if (!pwm_sel_live)
						duty_compare_latch <= wbyte_reg;
				end
				default: ;
				endcase
			end
			// Hardware load of the latch at the boundary
			if (period_start && pwm_sel_live)
				duty_compare_latch <= duty_high_buffer;
		end
	end

	// Read channel, one cycle from address to data
	always @* begin
		rd_hit  = mapped(s_axi_araddr);
		rd_next = 32'h00000000;
		case (reg_index(s_axi_araddr))
		`EBP_IDX_MODULE_CTRL:  rd_next[7:0] = module_control_reg;
		`EBP_IDX_DUTY_HIGH:    rd_next[7:0] = duty_high_buffer;
		`EBP_IDX_DUTY_LATCH:   rd_next[7:0] = duty_compare_latch;
		`EBP_IDX_PERIOD_LIMIT: rd_next[7:0] = period_limit_reg;
		`EBP_IDX_TIMER_CTRL:   rd_next[7:0] = period_timer_control;
		`EBP_IDX_DEADBAND:     rd_next[7:0] = deadband_config_reg;
		`EBP_IDX_STATUS:
			rd_next[13:0] = {pwm_raw_reg, cfg_sh_reg[1],
				pwm_out_d, pwm_out_c, pwm_out_b, pwm_out_a, period_timer};
		default:               rd_next = 32'h00000000;
		endcase
		if (!rd_hit)
			rd_next = 32'h00000000;
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `EBP_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_next;
			s_axi_rresp   <= rd_hit ? `EBP_RESP_OKAY : `EBP_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Shadow controls, taken when the timer resets; cleared at once when the control register is zero
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg_sh_reg     <= 2'b00;
			mode_sh_reg    <= 4'h0;
			duty_lo_sh_reg <= 2'b00;
		end else if (module_control_reg == `EBP_RST_BYTE) begin
			cfg_sh_reg     <= 2'b00;
			mode_sh_reg    <= 4'h0;
			duty_lo_sh_reg <= 2'b00;
		end else if (period_start) begin
			cfg_sh_reg     <= module_control_reg[`EBP_CFG_HI:`EBP_CFG_LO];
			mode_sh_reg    <= module_control_reg[`EBP_MODE_HI:`EBP_MODE_LO];
			duty_lo_sh_reg <= module_control_reg[`EBP_DUTYLO_HI:`EBP_DUTYLO_LO];
		end
	end

	// Raw waveform: set at period start, cleared on duty match
	always @(posedge clk or posedge rst) begin
		if (rst)
			pwm_raw_reg <= 1'b0;
		else if (module_control_reg == `EBP_RST_BYTE || !pwm_sel_live)
			pwm_raw_reg <= 1'b0;
		else if (period_start)
			pwm_raw_reg <= (module_control_reg[`EBP_DUTYLO_HI:`EBP_DUTYLO_LO]
				!= 2'b00) || (duty_high_buffer != 8'h00);
		else if (duty_match)
			pwm_raw_reg <= 1'b0;
	end

	// Steering per configuration, then polarity
	always @* begin
		a_next   = 1'b0;
		b_next   = 1'b0;
		c_next   = 1'b0;
		d_next   = 1'b0;
		own_next = 4'b0000;
		if (pwm_sel_sh) begin
			case (cfg_sh_reg)
			`EBP_CFG_SINGLE: begin
				a_next   = pwm_raw_reg;
				own_next = 4'b0001;
			end
			`EBP_CFG_HALF: begin
				a_next   = db_a;
				b_next   = db_b;
				own_next = 4'b0011;
			end
			`EBP_CFG_FULLFWD: begin
				a_next   = 1'b1;
				d_next   = pwm_raw_reg;
				own_next = 4'b1111;
			end
			default: begin
				c_next   = 1'b1;
				b_next   = pwm_raw_reg;
				own_next = 4'b1111;
			end
			endcase
			// Early swap in the final count, held through the boundary
			// clock so A and C do not flip back before the shadows load
			if (full_sh && (last_count || period_start)
				&& (dir_live != cfg_sh_reg[1])) begin
				a_next = ~dir_live;
				c_next = dir_live;
				b_next = 1'b0;
				d_next = 1'b0;
			end
			a_next = a_next ^ mode_sh_reg[1];
			c_next = c_next ^ mode_sh_reg[1];
			b_next = b_next ^ mode_sh_reg[0];
			d_next = d_next ^ mode_sh_reg[0];
		end
	end

	// Registered pins
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			pwm_out_a   <= 1'b0;
			pwm_out_b   <= 1'b0;
			pwm_out_c   <= 1'b0;
			pwm_out_d   <= 1'b0;
			pwm_pin_own <= 4'b0000;
		end else begin
			pwm_out_a   <= a_next;
			pwm_out_b   <= b_next;
			pwm_out_c   <= c_next;
			pwm_out_d   <= d_next;
			pwm_pin_own <= own_next;
		end
	end
endmodule // ebp_bridge_pwm

/* dv/ebp_bridge_pwm_checker.sv */
// Port-level assertions for the bridge PWM block
`timescale 1ns/10ps
module ebp_bridge_pwm_checker (
	input logic        clk,           // Clock
	input logic        rst,           // Reset
	input logic [31:0] s_axi_awaddr,  // Write address
	input logic        s_axi_awvalid, // Aw valid
	input logic        s_axi_awready, // Aw ready
	input logic [31:0] s_axi_wdata,   // Write data
	input logic [3:0]  s_axi_wstrb,   // Strobes
	input logic        s_axi_wvalid,  // W valid
	input logic        s_axi_wready,  // W ready
	input logic [1:0]  s_axi_bresp,   // B response
	input logic        s_axi_bvalid,  // B valid
	input logic        s_axi_bready,  // B ready
	input logic        s_axi_arvalid, // Ar valid
	input logic        s_axi_arready, // Ar ready
	input logic [31:0] s_axi_rdata,   // Read data
	input logic        s_axi_rvalid,  // R valid
	input logic        s_axi_rready,  // R ready
	input logic        pwm_out_a,     // Output A
	input logic        pwm_out_b,     // Output B
	input logic        pwm_out_c,     // Output C
	input logic        pwm_out_d,     // Output D
	input logic [3:0]  pwm_pin_own    // Pin ownership
);
	logic wr_both;
	// Both write channels taken at one edge
	assign wr_both = s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_reset_idle: assert property (disable iff (1'b0)
		rst |-> !(pwm_out_a | pwm_out_b | pwm_out_c | pwm_out_d)
		&& pwm_pin_own == 4'h0 && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active during reset");
	chk_write_answer: assert property (wr_both |=> ##1 s_axi_bvalid)
		else $error("write response late");
	chk_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_one_write: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	chk_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	chk_pin_set: assert property (
		pwm_pin_own inside {4'h0, 4'h1, 4'h3, 4'hf})
		else $error("illegal pin ownership");
	chk_clear_idle: assert property (
		wr_both && s_axi_awaddr == 32'h54 && s_axi_wstrb[0]
		&& s_axi_wdata[7:0] == 8'h00 |-> ##[1:4]
		!(pwm_out_a | pwm_out_b | pwm_out_c | pwm_out_d))
		else $error("outputs not idle after control clear");
	chk_bridge_excl: assert property (
		(pwm_pin_own == 4'hf) [*3] |-> pwm_out_a ^ pwm_out_c)
		else $error("bridge A and C not exclusive");
	cov_write: cover property (s_axi_bvalid && s_axi_bready);
	cov_read: cover property (s_axi_rvalid && s_axi_rready);
	cov_full: cover property (pwm_pin_own == 4'hf && pwm_out_c);
endmodule // ebp_bridge_pwm_checker
bind ebp_bridge_pwm ebp_bridge_pwm_checker u_chk (.*);

/* dv/ebp_drv_model.sv */
// Bridge driver model counting active clocks per gate input
`timescale 1ns/10ps
module ebp_drv_model (
	input  logic        clk,         // Clock
	input  logic        cnt_clr,     // Restart counts
	input  logic        pwm_out_a,   // Gate input A
	input  logic        pwm_out_b,   // Gate input B
	input  logic        pwm_out_c,   // Gate input C
	input  logic        pwm_out_d,   // Gate input D
	input  logic [3:0]  pwm_pin_own, // Pins handed to PWM
	output logic [15:0] hi_a,        // High clocks on A
	output logic [15:0] hi_b,        // High clocks on B
	output logic [15:0] hi_c,        // High clocks on C
	output logic [15:0] hi_d         // High clocks on D
);
	// Only pins handed over to PWM reach the switches
	always @(posedge clk) begin
		hi_a <= (cnt_clr ? 16'h0 : hi_a) + 16'(pwm_out_a & pwm_pin_own[0]);
		hi_b <= (cnt_clr ? 16'h0 : hi_b) + 16'(pwm_out_b & pwm_pin_own[1]);
		hi_c <= (cnt_clr ? 16'h0 : hi_c) + 16'(pwm_out_c & pwm_pin_own[2]);
		hi_d <= (cnt_clr ? 16'h0 : hi_d) + 16'(pwm_out_d & pwm_pin_own[3]);
	end
endmodule // ebp_drv_model

/* dv/ebp_bridge_pwm_tb.sv */
// Self-checking bench for the bridge PWM block
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module ebp_bridge_pwm_tb;
	localparam logic [31:0] A_DUTY = 32'h4c, A_LATCH = 32'h50;
	localparam logic [31:0] A_CTRL = 32'h54, A_DB = 32'h58;
	localparam logic [31:0] A_PER = 32'h80, A_TCTL = 32'h84;
	logic        clk, rst, cnt_clr;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready;
	logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0]  s_axi_wstrb, pwm_pin_own;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
	logic [3:0]  abcd;
	logic [15:0] hi_a, hi_b, hi_c, hi_d;
	int          n_fail = 0, n_compared = 0, cycles = 0;

	ebp_bridge_pwm u_dut (.*);
	ebp_drv_model u_drv (.*);
	// Pins A..D as one nibble, A in the top bit
	assign abcd = {pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d};

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			n_fail++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Write with both channels offered together, late bready
	task automatic wr(input logic [31:0] a, input logic [7:0] d,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge clk);
		`CHK(s_axi_bresp, er)
		s_axi_bready <= 1'b0;
	endtask
	// Read with late rready, data and response compared
	task automatic rdr(input logic [31:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge clk);
		`CHK(s_axi_rdata, ed)
		`CHK(s_axi_rresp, er)
		s_axi_rready <= 1'b0;
	endtask
	// Settle three periods, then count over four whole periods
	task automatic meas(input int per);
		repeat (3 * per) @(posedge clk);
		cnt_clr <= 1'b1;
		@(posedge clk);
		cnt_clr <= 1'b0;
		repeat (4 * per) @(posedge clk);
	endtask
	task automatic pins(input int a, input int b, input int c, input int d);
		`CHK(hi_a, 16'(a))
		`CHK(hi_b, 16'(b))
		`CHK(hi_c, 16'(c))
		`CHK(hi_d, 16'(d))
	endtask
	// Reset values, field widths, refused lane and address
	task automatic t_regs();
		rdr(A_CTRL, 32'h0, 2'b00);
		rdr(A_PER, 32'hff, 2'b00);
		rdr(32'h88, 32'h0, 2'b00);
		wr(A_DB, 8'hff, 2'b00);
		rdr(A_DB, 32'h7f, 2'b00);
		s_axi_wstrb <= 4'he;
		wr(A_DB, 8'h00, 2'b00);
		s_axi_wstrb <= 4'hf;
		rdr(A_DB, 32'h7f, 2'b00);
		wr(32'h3c, 8'h55, 2'b10);
		rdr(32'h3c, 32'h0, 2'b10);
		wr(A_DB, 8'h00, 2'b00);
	endtask
	// Single output, duty latch loaded and write-protected
	task automatic t_latch();
		wr(A_PER, 8'h09, 2'b00);
		wr(A_TCTL, 8'h04, 2'b00);
		wr(A_DUTY, 8'h03, 2'b00);
		wr(A_CTRL, 8'h0c, 2'b00);
		repeat (120) @(posedge clk);
		rdr(A_LATCH, 32'h03, 2'b00);
		wr(A_LATCH, 8'haa, 2'b00);
		rdr(A_LATCH, 32'h03, 2'b00);
		`CHK(pwm_pin_own, 4'h1)
	endtask
	// Period and duty scale with each prescale value
	task automatic t_prescale();
		for (int i = 0; i < 3; i++) begin
			wr(A_TCTL, 8'h04 | 8'(i), 2'b00);
			meas(40 << (2 * i));
			`CHK(hi_a, 16'(48 << (2 * i)))
		end
		wr(A_TCTL, 8'h04, 2'b00);
	endtask
	// Low duty bits, zero duty, duty beyond period, control clear
	task automatic t_edges();
		wr(A_CTRL, 8'h2c, 2'b00);
		meas(40);
		`CHK(hi_a, 16'd56)
		wr(A_CTRL, 8'h0c, 2'b00);
		wr(A_DUTY, 8'h00, 2'b00);
		meas(40);
		`CHK(hi_a, 16'h0)
		wr(A_DUTY, 8'h0f, 2'b00);
		meas(40);
		`CHK(hi_a, 16'd160)
		wr(A_CTRL, 8'h00, 2'b00);
		repeat (4) @(posedge clk);
		`CHK({pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d}, 4'h0)
		wr(A_DUTY, 8'h03, 2'b00);
	endtask
	// Half-bridge complement with rising-edge dead band
	task automatic t_half();
		wr(A_CTRL, 8'h8c, 2'b00);
		for (int i = 0; i < 3; i++) begin
			wr(A_DB, 8'(2 * i), 2'b00);
			meas(40);
			`CHK(pwm_pin_own, 4'h3)
			`CHK(hi_a, 16'(i < 2 ? 48 - 32 * i : 0))
			`CHK(hi_b, 16'(112 - 32 * i))
		end
	endtask
	// Full bridge, every polarity code, then reverse
	task automatic t_full();
		wr(A_DB, 8'h05, 2'b00);
		for (int m = 0; m < 4; m++) begin
			wr(A_CTRL, 8'h4c | 8'(m), 2'b00);
			meas(40);
			`CHK(pwm_pin_own, 4'hf)
			pins(m[1] ? 0 : 160, m[0] ? 160 : 0, m[1] ? 160 : 0,
				m[0] ? 112 : 48);
		end
		wr(A_CTRL, 8'hcc, 2'b00);
		meas(40);
		pins(0, 48, 160, 0);
		// Back to forward at a known phase: A must lead D by the swap
		while (pwm_out_b) @(posedge clk);
		while (!pwm_out_b) @(posedge clk);
		wr(A_CTRL, 8'h4c, 2'b00);
		`CHK(abcd, 4'h6)
		while (!pwm_out_a) @(posedge clk);
		`CHK(abcd, 4'h8)
		repeat (4) @(posedge clk);
		`CHK(abcd, 4'h8)
		@(posedge clk);
		`CHK(abcd, 4'h9)
	endtask

	// Reset, then the scenarios in order
	initial begin
		rst = 1'b1;
		cnt_clr = 1'b0;
		s_axi_awaddr = 32'h0;
		s_axi_wdata = 32'h0;
		s_axi_araddr = 32'h0;
		s_axi_wstrb = 4'hf;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_latch();
		t_prescale();
		t_edges();
		t_half();
		t_full();
		final_report();
	end
endmodule // ebp_bridge_pwm_tb
